// File: shared/acs_pkg.sv
// Package of constants, field positions and helpers for the console serial channel.
// ---------------------------------------------------------------------------
// Summary of operation
// R1 - One eight-bit data buffer for all characters.
// R2 - Write loads transmit holder; read returns receive holder.
// R3 - Software clears status before first use.
// R4 - Six status flags, cleared by initialisation write.
// R5 - Status shows errors and running transfer state.
// R6 - Bit timing comes from timer overflow pulse.
// R7 - Software sets timer reload for chosen rate.
// R8 - Transmit control selects format and interrupt enables; the enable bits are only stored and no interrupt is raised.
// R9 - Receive control selects size, clock, parity, enable.
// R10 - Output on port pin 1, input pin 0.
// R11 - Software sets direction and alternate bits for pins.
// R12 - Echo received characters; carriage return becomes CR-LF.
// R13 - Insert carriage return before each line feed written to the buffer; echoed line feeds go out without it.
// R14 - Low start, LSB first, high stop, idle high.
// R15 - Direction 1 output; alternate 1 secondary; reset zero.
// ---------------------------------------------------------------------------
package acs_pkg;

    // -----------------------------------------------------------------------
    // Register byte addresses
    // -----------------------------------------------------------------------
    localparam logic [4:0] ACS_OFF_TXCTL  = 5'h00;
    localparam logic [4:0] ACS_OFF_RXCTL  = 5'h04;
    localparam logic [4:0] ACS_OFF_BUF    = 5'h08;
    localparam logic [4:0] ACS_OFF_STAT   = 5'h0C;
    localparam logic [4:0] ACS_OFF_PDIR   = 5'h10;
    localparam logic [4:0] ACS_OFF_PALT   = 5'h14;
    localparam logic [4:0] ACS_OFF_PDAT   = 5'h18;
    localparam logic [4:0] ACS_OFF_RELOAD = 5'h1C;

    // -----------------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------------
    localparam int FMT_SEVEN   = 0;
    localparam int TXC_TWOSTOP = 1;
    localparam int RXC_CLKSEL  = 1;
    localparam int FMT_PAR     = 2;
    localparam int FMT_ODD     = 3;
    localparam int TXC_TXE_IE  = 4;
    localparam int TXC_END_IE  = 5;
    localparam int RXC_END_IE  = 4;
    localparam int RXC_EN      = 5;
    localparam int ST_FE       = 0;
    localparam int ST_OE       = 1;
    localparam int ST_PE       = 2;
    localparam int ST_TXE      = 3;
    localparam int ST_TXEND    = 4;
    localparam int ST_RXEND    = 5;
    localparam int PIN_TX      = 1;
    localparam int PIN_RX      = 0;

    // -----------------------------------------------------------------------
    // Reset values and timing
    // -----------------------------------------------------------------------
    localparam logic [7:0]  ACS_CTL_RST  = 8'h00;
    localparam logic [7:0]  ACS_PORT_RST = 8'h00;
    localparam logic [5:0]  ACS_STAT_RST = 6'h00;
    localparam int          ACS_CLK_HZ   = 40000000;
    localparam int          ACS_BAUD     = 38400;
    localparam int          ACS_OVS      = 16;
    localparam logic [15:0] ACS_RELOAD_RST = 16'(ACS_CLK_HZ / (ACS_BAUD * ACS_OVS) - 1);
    localparam logic [7:0]  ACS_CR       = 8'h0D;
    localparam logic [7:0]  ACS_LF       = 8'h0A;

    // -----------------------------------------------------------------------
    // Helpers for transmitter and receiver (acs_frame serves the transmitter only)
    // -----------------------------------------------------------------------
    function automatic logic acs_par(input logic [7:0] d, input logic [7:0] ctl);
        logic [7:0] m;
        m = ctl[FMT_SEVEN] ? 8'h7F : 8'hFF;
        return (^(d & m)) ^ ctl[FMT_ODD];
    endfunction

    function automatic logic [3:0] acs_nbits(input logic [7:0] ctl);
        return (ctl[FMT_SEVEN] ? 4'h7 : 4'h8) + {3'h0, ctl[FMT_PAR]};
    endfunction

    function automatic logic [11:0] acs_frame(input logic [7:0] d, input logic [7:0] ctl);
        logic [11:0] f;
        f = 12'hFFF;
        f[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < 7 || !ctl[FMT_SEVEN]) begin
                f[i+1] = d[i];
            end
        end
        if (ctl[FMT_PAR]) begin
            f[ctl[FMT_SEVEN] ? 8 : 9] = acs_par(d, ctl);
        end
        return f;
    endfunction

endpackage

// File: rtl/acs_bit_timer.sv
// Reload timer whose overflow pulse paces the serial channel.
`timescale 1ns/1ps
module acs_bit_timer
    import acs_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] reload,
    input  wire logic         run,
    output logic              ovf
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         ovf_q;
    logic         ovf_d;

    // -----------------------------------------------------------------------
    // Down counter
    // -----------------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (!run) begin
            cnt_d = reload;
        end else if (cnt_q == '0) begin
            cnt_d = reload; // R6
            ovf_d = 1'b1;
        end else begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign ovf = ovf_q;

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    property p_ovf_period;
        @(posedge clk) disable iff (!rst_n)
        ovf_q && run && $stable(reload) |-> cnt_q == reload;
    endproperty
    a_ovf_period: assert property (p_ovf_period) else $error("timer did not reload"); // R6

endmodule

// File: rtl/acs_console_uart.sv
// Console serial channel with Avalon-MM registers, CR/LF handling and port pins.
`timescale 1ns/1ps
module acs_console_uart
    import acs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  port_in,
    output logic [7:0]       port_out,
    output logic [7:0]       port_oe
);

    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} acs_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} acs_rx_st_t;

    // -----------------------------------------------------------------------
    // Bus slave
    // -----------------------------------------------------------------------
    // Every access waits exactly one cycle so read data always come from a flop.
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        req;
    logic        wr_done;
    logic        rd_done;
    logic [7:0]  wd;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_done         = avs_write & ack_q;
    assign rd_done         = avs_read & ack_q;
    assign wd              = avs_writedata[7:0];
    assign avs_readdata    = rdata_q;

    // -----------------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------------
    logic [7:0]  txc_q, txc_d;
    logic [7:0]  rxc_q, rxc_d;
    logic [5:0]  stat_q, stat_d;
    logic [7:0]  pdir_q, pdir_d;
    logic [7:0]  palt_q, palt_d;
    logic [7:0]  pdat_q, pdat_d;
    logic [7:0]  pout_q, pout_d;
    logic [15:0] rld_q, rld_d;
    logic [7:0]  hold_q, hold_d;
    logic        hold_v_q, hold_v_d;
    logic        hold_take;
    logic [5:0]  ev;
    logic        tick;
    logic        tx_run;
    logic        rx_run;
    logic        txd;
    logic [7:0]  rxbuf_q, rxbuf_d;
    logic        rx_full_q, rx_full_d;

    acs_bit_timer #(
        .W (16)
    ) u_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .reload (rld_q),
        .run    (rxc_q[RXC_CLKSEL]),
        .ovf    (tick)
    );

    always_comb begin
        ack_d   = req & ~ack_q;
        rdata_d = rdata_q;
        txc_d   = txc_q;
        rxc_d   = rxc_q;
        stat_d  = stat_q;
        pdir_d  = pdir_q;
        palt_d  = palt_q;
        pdat_d  = pdat_q;
        rld_d   = rld_q;
        hold_d  = hold_q;
        hold_v_d = hold_v_q & ~hold_take;
        if (avs_read && !ack_q) begin
            case (avs_address)
                ACS_OFF_TXCTL:  rdata_d = {24'h000000, txc_q};
                ACS_OFF_RXCTL:  rdata_d = {24'h000000, rxc_q};
                ACS_OFF_BUF:    rdata_d = {24'h000000, rxbuf_q}; // R2
                ACS_OFF_STAT:   rdata_d = {24'h000000, rx_run, tx_run, stat_q}; // R5
                ACS_OFF_PDIR:   rdata_d = {24'h000000, pdir_q};
                ACS_OFF_PALT:   rdata_d = {24'h000000, palt_q};
                ACS_OFF_PDAT:   rdata_d = {24'h000000, pdat_q};
                ACS_OFF_RELOAD: rdata_d = {16'h0000, rld_q};
                default:        rdata_d = 32'h00000000;
            endcase
        end
        if (wr_done && avs_byteenable[0]) begin
            case (avs_address)
                ACS_OFF_TXCTL: txc_d = wd; // R8
                ACS_OFF_RXCTL: rxc_d = wd; // R9
                ACS_OFF_BUF: begin
                    hold_d   = wd; // R1 R2
                    hold_v_d = 1'b1;
                    stat_d[ST_TXE] = 1'b0;
                end
                ACS_OFF_STAT:   stat_d = wd[5:0]; // R4
                ACS_OFF_PDIR:   pdir_d = wd; // R15
                ACS_OFF_PALT:   palt_d = wd; // R15
                ACS_OFF_PDAT:   pdat_d = wd;
                ACS_OFF_RELOAD: rld_d[7:0] = wd;
                default: ;
            endcase
        end
        if (wr_done && avs_byteenable[1] && avs_address == ACS_OFF_RELOAD) begin
            rld_d[15:8] = avs_writedata[15:8];
        end
        // Hardware events win over a clearing write in the same cycle.
        stat_d = stat_d | ev;
        pout_d = pdat_d;
        pout_d[PIN_TX] = palt_d[PIN_TX] ? txd : pdat_d[PIN_TX]; // R10
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q    <= 1'b0;
            rdata_q  <= 32'h00000000;
            txc_q    <= ACS_CTL_RST;
            rxc_q    <= ACS_CTL_RST;
            stat_q   <= ACS_STAT_RST;
            pdir_q   <= ACS_PORT_RST;
            palt_q   <= ACS_PORT_RST;
            pdat_q   <= ACS_PORT_RST;
            pout_q   <= ACS_PORT_RST;
            rld_q    <= ACS_RELOAD_RST;
            hold_q   <= 8'h00;
            hold_v_q <= 1'b0;
        end else begin
            ack_q    <= ack_d;
            rdata_q  <= rdata_d;
            txc_q    <= txc_d;
            rxc_q    <= rxc_d;
            stat_q   <= stat_d;
            pdir_q   <= pdir_d;
            palt_q   <= palt_d;
            pdat_q   <= pdat_d;
            pout_q   <= pout_d;
            rld_q    <= rld_d;
            hold_q   <= hold_d;
            hold_v_q <= hold_v_d;
        end
    end

    assign port_out = pout_q;
    assign port_oe  = pdir_q; // R15

    // -----------------------------------------------------------------------
    // Receiver
    // -----------------------------------------------------------------------
    acs_rx_st_t rx_st_q, rx_st_d;
    logic [3:0] rph_q, rph_d;
    logic [3:0] ridx_q, ridx_d;
    logic [9:0] rbits_q, rbits_d;
    logic       rxd;
    logic       rx_done;
    logic [7:0] rx_raw;
    logic [3:0] rnb;
    logic       ev_fe, ev_pe, ev_oe;

    // With the alternate function off the receiver sees an idle line.
    assign rxd    = palt_q[PIN_RX] ? port_in[PIN_RX] : 1'b1;
    assign rnb    = acs_nbits(rxc_q);
    assign rx_run = (rx_st_q != RX_IDLE);

    always_comb begin
        rx_st_d   = rx_st_q;
        rph_d     = rph_q;
        ridx_d    = ridx_q;
        rbits_d   = rbits_q;
        rx_done   = 1'b0;
        rx_raw    = 8'h00;
        ev_fe     = 1'b0;
        ev_pe     = 1'b0;
        ev_oe     = 1'b0;
        rxbuf_d   = rxbuf_q;
        rx_full_d = rx_full_q & ~(rd_done && avs_address == ACS_OFF_BUF);
        unique case (rx_st_q)
            RX_IDLE: begin
                if (rxc_q[RXC_EN] && !rxd) begin // R14
                    rph_d   = 4'h0;
                    rx_st_d = RX_START;
                end
            end
            RX_START: begin
                if (!rxc_q[RXC_EN]) begin
                    rx_st_d = RX_IDLE;
                end else if (tick) begin
                    rph_d = rph_q + 4'h1;
                    if (rph_q == 4'(ACS_OVS / 2 - 1)) begin
                        rph_d   = 4'h0;
                        ridx_d  = 4'h0;
                        rx_st_d = rxd ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA: begin
                if (!rxc_q[RXC_EN]) begin
                    rx_st_d = RX_IDLE;
                end else if (tick) begin
                    rph_d = rph_q + 4'h1;
                    if (rph_q == 4'(ACS_OVS - 1)) begin
                        rbits_d[ridx_q] = rxd; // R14
                        ridx_d = ridx_q + 4'h1;
                        if (ridx_q == rnb) begin
                            rx_done = 1'b1;
                            rx_st_d = RX_IDLE;
                        end
                    end
                end
            end
        endcase
        if (rx_done) begin
            rx_raw = rbits_d[7:0] & (rxc_q[FMT_SEVEN] ? 8'h7F : 8'hFF);
            ev_fe  = !rbits_d[rnb]; // R4
            ev_pe  = rxc_q[FMT_PAR] && (rbits_d[rnb - 4'h1] != acs_par(rx_raw, rxc_q));
            ev_oe  = rx_full_q;
            rxbuf_d   = (rx_raw == ACS_CR) ? ACS_LF : rx_raw; // R12
            rx_full_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_st_q   <= RX_IDLE;
            rph_q     <= 4'h0;
            ridx_q    <= 4'h0;
            rbits_q   <= 10'h000;
            rxbuf_q   <= 8'h00;
            rx_full_q <= 1'b0;
        end else begin
            rx_st_q   <= rx_st_d;
            rph_q     <= rph_d;
            ridx_q    <= ridx_d;
            rbits_q   <= rbits_d;
            rxbuf_q   <= rxbuf_d;
            rx_full_q <= rx_full_d;
        end
    end

    // -----------------------------------------------------------------------
    // Transmitter
    // -----------------------------------------------------------------------
    // One echo slot only: a character arriving while an echo still waits is
    // stored but not echoed, which a typing user never reaches at this rate.
    acs_tx_st_t  tx_st_q, tx_st_d;
    logic [11:0] sh_q, sh_d;
    logic [3:0]  nb_q, nb_d;
    logic [3:0]  ph_q, ph_d;
    logic        cr_sent_q, cr_sent_d;
    logic [7:0]  echo_q, echo_d;
    logic        echo_v_q, echo_v_d;
    logic        echo_lf_q, echo_lf_d;
    logic [7:0]  ch;
    logic        load;
    logic        ev_txe, ev_txend;

    assign tx_run = (tx_st_q != TX_IDLE);

    always_comb begin
        tx_st_d   = tx_st_q;
        sh_d      = sh_q;
        nb_d      = nb_q;
        ph_d      = ph_q;
        cr_sent_d = cr_sent_q;
        echo_d    = echo_q;
        echo_v_d  = echo_v_q;
        echo_lf_d = echo_lf_q;
        ch        = 8'h00;
        load      = 1'b0;
        hold_take = 1'b0;
        ev_txe    = 1'b0;
        ev_txend  = 1'b0;
        unique case (tx_st_q)
            TX_IDLE: begin
                if (echo_v_q) begin
                    ch   = echo_q;
                    load = 1'b1;
                    if (echo_lf_q) begin
                        echo_d    = ACS_LF; // R12
                        echo_lf_d = 1'b0;
                    end else begin
                        echo_v_d = 1'b0;
                    end
                end else if (hold_v_q) begin
                    load = 1'b1;
                    if (hold_q == ACS_LF && !cr_sent_q) begin
                        ch        = ACS_CR; // R13
                        cr_sent_d = 1'b1;
                    end else begin
                        ch        = hold_q;
                        cr_sent_d = 1'b0;
                        hold_take = 1'b1;
                        ev_txe    = 1'b1;
                    end
                end
                if (load) begin
                    sh_d    = acs_frame(ch, txc_q); // R8 R14
                    nb_d    = acs_nbits(txc_q) + 4'h2 + {3'h0, txc_q[TXC_TWOSTOP]};
                    ph_d    = 4'h0;
                    tx_st_d = TX_RUN;
                end
            end
            TX_RUN: begin
                if (tick) begin
                    ph_d = ph_q + 4'h1;
                    if (ph_q == 4'(ACS_OVS - 1)) begin
                        sh_d = {1'b1, sh_q[11:1]}; // R14
                        nb_d = nb_q - 4'h1;
                        if (nb_q == 4'h1) begin
                            tx_st_d  = TX_IDLE;
                            ev_txend = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (rx_done && !echo_v_q) begin
            echo_d    = rx_raw; // R12
            echo_v_d  = 1'b1;
            echo_lf_d = (rx_raw == ACS_CR);
        end
    end

    assign txd = (tx_st_d == TX_RUN) ? sh_d[0] : 1'b1;
    assign ev  = {rx_done, ev_txend, ev_txe, ev_pe, ev_oe, ev_fe};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_st_q   <= TX_IDLE;
            sh_q      <= 12'hFFF;
            nb_q      <= 4'h0;
            ph_q      <= 4'h0;
            cr_sent_q <= 1'b0;
            echo_q    <= 8'h00;
            echo_v_q  <= 1'b0;
            echo_lf_q <= 1'b0;
        end else begin
            tx_st_q   <= tx_st_d;
            sh_q      <= sh_d;
            nb_q      <= nb_d;
            ph_q      <= ph_d;
            cr_sent_q <= cr_sent_d;
            echo_q    <= echo_d;
            echo_v_q  <= echo_v_d;
            echo_lf_q <= echo_lf_d;
        end
    end

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_lf_first;
        tx_st_q == TX_IDLE && !echo_v_q && hold_v_q && hold_q == ACS_LF && !cr_sent_q;
    endsequence
    sequence s_lf_second;
        ##1 tx_st_q == TX_RUN && cr_sent_q && hold_v_q;
    endsequence

    property p_lf_insert;
        s_lf_first |-> s_lf_second;
    endproperty
    a_lf_insert: assert property (p_lf_insert) else $error("no CR before LF"); // R13

    property p_cr_frame;
        s_lf_first |=> sh_q[8:1] == ACS_CR;
    endproperty
    a_cr_frame: assert property (p_cr_frame) else $error("inserted char not CR"); // R13

    property p_wait_one;
        req && !ack_q |=> ack_q && (!req || !avs_waitrequest);
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer not one cycle late");

    property p_rd_buf;
        avs_read && !ack_q && avs_address == ACS_OFF_BUF |=> avs_readdata[7:0] == $past(rxbuf_q);
    endproperty
    a_rd_buf: assert property (p_rd_buf) else $error("buffer read not receive holder"); // R2

    property p_stat_clear;
        wr_done && avs_byteenable[0] && avs_address == ACS_OFF_STAT && wd == 8'h00 && ev == 6'h00
            |=> stat_q == 6'h00;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status not cleared"); // R4

    property p_rx_cr_lf;
        rx_done && rx_raw == ACS_CR |=> rxbuf_q == ACS_LF && stat_q[ST_RXEND];
    endproperty
    a_rx_cr_lf: assert property (p_rx_cr_lf) else $error("CR not stored as LF"); // R12

    property p_echo_cr;
        rx_done && rx_raw == ACS_CR && !echo_v_q |=> echo_v_q && echo_lf_q && echo_q == ACS_CR;
    endproperty
    a_echo_cr: assert property (p_echo_cr) else $error("CR echo not queued with LF"); // R12

    property p_start_low;
        tx_st_q == TX_IDLE ##1 tx_st_q == TX_RUN |-> sh_q[0] == 1'b0 && ph_q == 4'h0;
    endproperty
    a_start_low: assert property (p_start_low) else $error("frame without start bit"); // R14

    property p_pin_tx;
        palt_q[PIN_TX] && tx_st_q == TX_IDLE && $past(tx_st_q) == TX_IDLE
            && $past(palt_q[PIN_TX]) |-> port_out[PIN_TX];
    endproperty
    a_pin_tx: assert property (p_pin_tx) else $error("idle line not high on pin"); // R10

    property p_run_flag;
        rx_st_q != RX_IDLE && avs_read && !ack_q && avs_address == ACS_OFF_STAT
            |=> avs_readdata[7];
    endproperty
    a_run_flag: assert property (p_run_flag) else $error("receive running not shown"); // R5

endmodule

// File: verif/acs_term_model.sv
// Terminal emulator model on the far side of the console serial line.
`timescale 1ns/1ps
module acs_term_model #(
    parameter int BIT_CLKS = 32
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got_q [$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    // Bits are sampled mid-cell; a byte with a low stop bit is dropped, so a bad frame shows as loss.
    always begin
        @(posedge clk iff txd === 1'b0);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            sh[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge clk);
        if (txd === 1'b1) begin
            got_q.push_back(sh);
        end
    end
    task automatic send(input logic [7:0] b, input logic stp);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
        @(posedge clk);
        rxd <= 1'b1;
    endtask
endmodule

// File: verif/acs_console_uart_bench.sv
// Self-checking bench for the console serial channel and its register bus.
`timescale 1ns/1ps
module acs_console_uart_bench
    import acs_pkg::*;
;
    localparam int BITC = 2 * ACS_OVS;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  port_out;
    logic [7:0]  port_oe;
    wire         rxd;
    // The line has a pull-up, so an undriven pin reads as idle rather than a start bit.
    wire         txd = port_oe[PIN_TX] ? port_out[PIN_TX] : 1'b1;
    int          err_total = 0;
    int          total_checks = 0;
    logic [4:0]  offs [4] = '{ACS_OFF_TXCTL, ACS_OFF_RXCTL, ACS_OFF_PDIR, ACS_OFF_PALT};
    always #12.5 clk = ~clk;
    acs_console_uart uut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_in({7'h00, rxd}), .port_out(port_out), .port_oe(port_oe));
    acs_term_model #(.BIT_CLKS(BITC)) term (.clk(clk), .txd(txd), .rxd(rxd));
    // -----------------------------------------------------------------------
    // Bus and check tasks
    // -----------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        logic w;
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        // Sampled at the rising edge itself, before the registers move; ends once avs_waitrequest reads low, else only the watchdog ends it.
        do begin
            @(posedge clk);
            w = avs_waitrequest;
            rd = avs_readdata[7:0];
            n++;
        end while (w !== 1'b0);
        chk("bus waits", 8'h02, n[7:0]);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] x;
        acc(1'b1, a, d, x);
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] m,
                       input logic [7:0] e);
        logic [7:0] x;
        acc(1'b0, a, 8'h00, x);
        chk(nm, e, x & m);
    endtask
    task automatic tget(input logic [7:0] e);
        int n;
        logic [7:0] b;
        n = 0;
        b = 8'hXX;
        while (term.got_q.size() == 0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (term.got_q.size() != 0) begin
            b = term.got_q.pop_front();
        end
        chk("line byte", e, b);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // -----------------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (offs[i]) rdc("reset value", offs[i], 8'hFF, 8'h00);
        chk("pin enables", 8'h00, port_oe);
        $display("test reset done");
        wr(ACS_OFF_RELOAD, 8'h01);
        wr(ACS_OFF_RXCTL, 8'h32);
        wr(ACS_OFF_TXCTL, 8'h32);
        wr(ACS_OFF_STAT, 8'h00);
        wr(ACS_OFF_PALT, 8'h03);
        wr(ACS_OFF_PDIR, 8'h02);
        rdc("tx control", ACS_OFF_TXCTL, 8'hFF, 8'h32);
        rdc("rx control", ACS_OFF_RXCTL, 8'hFF, 8'h32);
        rdc("status", ACS_OFF_STAT, 8'h3F, 8'h00);
        chk("pin enables", 8'h02, port_oe);
        $display("test setup done");
        wr(ACS_OFF_BUF, 8'h41);
        rdc("tx state", ACS_OFF_STAT, 8'h48, 8'h48);
        tget(8'h41);
        wr(ACS_OFF_BUF, ACS_LF);
        tget(ACS_CR);
        tget(ACS_LF);
        $display("test transmit done");
        term.send(8'h55, 1'b1);
        tget(8'h55);
        rdc("rx end", ACS_OFF_STAT, 8'h20, 8'h20);
        rdc("rx data", ACS_OFF_BUF, 8'hFF, 8'h55);
        term.send(ACS_CR, 1'b1);
        tget(ACS_CR);
        tget(ACS_LF);
        rdc("rx data", ACS_OFF_BUF, 8'hFF, ACS_LF);
        $display("test receive done");
        wr(ACS_OFF_STAT, 8'h00);
        term.send(8'h31, 1'b1);
        term.send(8'h32, 1'b1);
        rdc("overrun", ACS_OFF_STAT, 8'h02, 8'h02);
        rdc("rx data", ACS_OFF_BUF, 8'hFF, 8'h32);
        wr(ACS_OFF_RXCTL, 8'h36);
        term.send(8'h5A, 1'b1);
        repeat (BITC) @(posedge clk);
        rdc("parity", ACS_OFF_STAT, 8'h04, 8'h04);
        wr(ACS_OFF_RXCTL, 8'h32);
        term.send(8'h5A, 1'b0);
        rdc("framing", ACS_OFF_STAT, 8'h01, 8'h01);
        $display("test errors done");
        final_report();
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule
